// ### shared/uart_defs.svh
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// ==========================================================
// register addresses
`define ADR_SERIAL_CONTROL_REG 8'h98
`define ADR_SBUF 8'h99
`define ADR_BRL 8'h9a
`define ADR_BAUD_GENERATOR_CONTROL_REG 8'h9b
`define ADR_POWER_CONTROL_REG 8'h87
`define ADR_SLAVE_ADDRESS 8'ha9
`define ADR_SLAVE_ADDRESS_MASK 8'hb9
`define ADR_TIMER_TWO_CONTROL_REG 8'hc8

// ==========================================================
// field positions
`define SERIAL_CONTROL_REG_FE_SM0 7
`define SERIAL_CONTROL_REG_SM1 6
`define SERIAL_CONTROL_REG_SM2 5
`define SERIAL_CONTROL_REG_REN 4
`define SERIAL_CONTROL_REG_TB8 3
`define SERIAL_CONTROL_REG_RB8 2
`define SERIAL_CONTROL_REG_TI 1
`define SERIAL_CONTROL_REG_RI 0
`define POWER_CONTROL_REG_BAUD_DOUBLING_BIT 7
`define POWER_CONTROL_REG_FRAMING_CHECK_ENABLE 6
`define TIMER_TWO_CONTROL_REG_RCLK 5
`define TIMER_TWO_CONTROL_REG_TRANSMIT_TIMER_TWO_SELECT 4
`define BDR_BRR 4
`define BDR_TRANSMIT_GENERATOR_SELECT 3
`define BDR_RECEIVE_GENERATOR_SELECT 2
`define BDR_SPD 1

// ==========================================================
// reset values
`define RST_BYTE 8'h00

// ==========================================================
// timing: generator prescale is 2*6 clocks slow, 2 clocks fast
`define BRG_PRE_SLOW 4'hb
`define BRG_PRE_FAST 4'h1
`define BRG_TOP 8'hff
`define OVS_LAST 4'hf
`define OVS_MID 4'h8
`define BITS_MODE1 4'h8
`define BITS_MODE23 4'h9

`endif

// ### shared/uart_pkg.sv
package uart_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b11,
        ST_STOP = 2'b10
    } frame_st_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfr_req_t;

    typedef struct packed {
        logic t1_ovf;
        logic t2_ovf;
    } timer_tick_t;

    typedef struct packed {
        logic sm0;
        logic sm1;
        logic sm2;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic fe;
        logic framing_check_enable;
        logic baud_doubling_bit;
        logic transmit_timer_two_select;
        logic rclk;
        logic brr;
        logic transmit_generator_select;
        logic receive_generator_select;
        logic speed_bit;
        logic [7:0] baud_reload_value;
        logic [7:0] slave_address;
        logic [7:0] slave_address_mask;
        logic [3:0] brg_pre;
        logic [7:0] brg_cnt;
        logic brg_half;
        logic m2_div;
        frame_st_t tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_ph;
        logic [3:0] tx_n;
        logic txd;
        frame_st_t rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_ph;
        logic [3:0] rx_n;
        logic rx_prev;
        logic rx_acc;
        logic [7:0] rx_buf;
        logic [7:0] rdata;
    } uart_state_t;

endpackage

// ### core/uart_addr_match_framing_brg.sv
`timescale 1ns/1ps
`include "uart_defs.svh"

module uart_addr_match_framing_brg (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire uart_pkg::sfr_req_t SFR_REQ_I,
    input wire uart_pkg::timer_tick_t TIMER_TICK_I,
    input wire logic RXD_I,
    output logic [7:0] RDATA_O,
    output logic TXD_O
);
    import uart_pkg::*;

    // ==========================================================
    // address filter
    function automatic logic addr_match(input logic [7:0] a, input logic [7:0] adr,
                                        input logic [7:0] msk);
        logic [7:0] bcast;
        bcast = adr | msk;
        addr_match = (((a ^ adr) & msk) == 8'h00)
                     || (((a ^ bcast) & bcast) == 8'h00);
    endfunction

    uart_state_t s_reg;
    uart_state_t s_next;

    logic [1:0] mode;
    logic pre_tc;
    logic brg_ovf;
    logic brg_tick;
    logic m2_tick;
    logic tx_tick;
    logic rx_tick;
    logic [3:0] nbits;
    logic wr_serial_control_reg;
    logic rx_mid;
    logic late_decide;
    logic [8:0] rx_shifted;
    logic [7:0] dec_data;
    logic dec_b9;
    logic dec_now;
    logic dec_accept;
    logic ri_set;
    logic fe_set;
    logic stop_bit_now;

    assign mode = {s_reg.sm0, s_reg.sm1};
    assign nbits = (mode == 2'b01) ? `BITS_MODE1 : `BITS_MODE23;
    assign wr_serial_control_reg = SFR_REQ_I.wr && (SFR_REQ_I.addr == `ADR_SERIAL_CONTROL_REG);

    // ==========================================================
    // baud sources
    assign pre_tc = (s_reg.brg_pre == (s_reg.speed_bit ? `BRG_PRE_FAST : `BRG_PRE_SLOW));
    assign brg_ovf = s_reg.brr && pre_tc && (s_reg.brg_cnt == `BRG_TOP);
    // without doubling the overflow is halved once more
    assign brg_tick = brg_ovf && (s_reg.baud_doubling_bit || s_reg.brg_half);
    assign m2_tick = s_reg.baud_doubling_bit || s_reg.m2_div;
    assign tx_tick = (mode == 2'b10) ? m2_tick :
                     s_reg.transmit_generator_select ? brg_tick :
                     s_reg.transmit_timer_two_select ? TIMER_TICK_I.t2_ovf : TIMER_TICK_I.t1_ovf;
    assign rx_tick = (mode == 2'b10) ? m2_tick :
                     s_reg.receive_generator_select ? brg_tick :
                     s_reg.rclk ? TIMER_TICK_I.t2_ovf : TIMER_TICK_I.t1_ovf;

    // ==========================================================
    // receive decision
    assign rx_mid = rx_tick && (s_reg.rx_ph == `OVS_MID);
    assign rx_shifted = {RXD_I, s_reg.rx_sh[8:1]};
    // mode 1 with address recognition must wait for the stop bit
    assign late_decide = s_reg.framing_check_enable || (s_reg.sm2 && mode == 2'b01);
    assign stop_bit_now = (s_reg.rx_st == ST_STOP) && rx_mid;
    always_comb begin
        dec_now = 1'b0;
        dec_data = s_reg.rx_sh[8:1];
        dec_b9 = RXD_I;
        if (stop_bit_now && late_decide) begin
            dec_now = 1'b1;
            dec_data = (mode == 2'b01) ? s_reg.rx_sh[8:1] : s_reg.rx_sh[7:0];
            dec_b9 = (mode == 2'b01) ? RXD_I : s_reg.rx_sh[8];
        end else if ((s_reg.rx_st == ST_DATA) && rx_mid && (s_reg.rx_n == nbits - 4'h1)
                     && !late_decide) begin
            dec_now = 1'b1;
            dec_data = (mode == 2'b01) ? rx_shifted[8:1] : rx_shifted[7:0];
            dec_b9 = (mode == 2'b01) ? 1'b1 : rx_shifted[8];
        end
    end
    // mode 0 never receives here, so the enable cannot act there
    assign dec_accept = !s_reg.ri && (!s_reg.sm2
                        || (dec_b9 && addr_match(dec_data, s_reg.slave_address, s_reg.slave_address_mask)));
    assign ri_set = dec_now && dec_accept;
    assign fe_set = stop_bit_now && s_reg.framing_check_enable && !RXD_I;

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        s_next.rx_prev = RXD_I;
        s_next.m2_div = !s_reg.m2_div;

        // register writes
        if (SFR_REQ_I.wr) begin
            case (SFR_REQ_I.addr)
                `ADR_SERIAL_CONTROL_REG: begin
                    if (s_reg.framing_check_enable) begin
                        s_next.fe = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_FE_SM0];
                    end else begin
                        s_next.sm0 = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_FE_SM0];
                    end
                    s_next.sm1 = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_SM1];
                    s_next.sm2 = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_SM2];
                    s_next.ren = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_REN];
                    s_next.tb8 = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_TB8];
                    s_next.rb8 = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_RB8];
                    s_next.ti = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_TI];
                    s_next.ri = SFR_REQ_I.wdata[`SERIAL_CONTROL_REG_RI];
                end
                `ADR_POWER_CONTROL_REG: begin
                    s_next.baud_doubling_bit = SFR_REQ_I.wdata[`POWER_CONTROL_REG_BAUD_DOUBLING_BIT];
                    s_next.framing_check_enable = SFR_REQ_I.wdata[`POWER_CONTROL_REG_FRAMING_CHECK_ENABLE];
                end
                `ADR_TIMER_TWO_CONTROL_REG: begin
                    s_next.rclk = SFR_REQ_I.wdata[`TIMER_TWO_CONTROL_REG_RCLK];
                    s_next.transmit_timer_two_select = SFR_REQ_I.wdata[`TIMER_TWO_CONTROL_REG_TRANSMIT_TIMER_TWO_SELECT];
                end
                `ADR_BAUD_GENERATOR_CONTROL_REG: begin
                    s_next.brr = SFR_REQ_I.wdata[`BDR_BRR];
                    s_next.transmit_generator_select = SFR_REQ_I.wdata[`BDR_TRANSMIT_GENERATOR_SELECT];
                    s_next.receive_generator_select = SFR_REQ_I.wdata[`BDR_RECEIVE_GENERATOR_SELECT];
                    s_next.speed_bit = SFR_REQ_I.wdata[`BDR_SPD];
                end
                `ADR_BRL: s_next.baud_reload_value = SFR_REQ_I.wdata;
                `ADR_SLAVE_ADDRESS: s_next.slave_address = SFR_REQ_I.wdata;
                `ADR_SLAVE_ADDRESS_MASK: s_next.slave_address_mask = SFR_REQ_I.wdata;
                `ADR_SBUF: begin
                    // a write while busy is dropped rather than corrupting the frame
                    if (s_reg.tx_st == ST_IDLE && mode != 2'b00) begin
                        s_next.tx_sh = {s_reg.tb8, SFR_REQ_I.wdata};
                        s_next.tx_st = ST_START;
                        s_next.tx_ph = 4'h0;
                        s_next.tx_n = 4'h0;
                        s_next.txd = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // register reads, data shows in the next cycle only
        if (SFR_REQ_I.rd) begin
            case (SFR_REQ_I.addr)
                `ADR_SERIAL_CONTROL_REG: s_next.rdata = {s_reg.framing_check_enable ? s_reg.fe : s_reg.sm0,
                    s_reg.sm1, s_reg.sm2, s_reg.ren, s_reg.tb8, s_reg.rb8, s_reg.ti, s_reg.ri};
                `ADR_SBUF: s_next.rdata = s_reg.rx_buf;
                `ADR_POWER_CONTROL_REG: s_next.rdata = {s_reg.baud_doubling_bit, s_reg.framing_check_enable, 6'h00};
                `ADR_TIMER_TWO_CONTROL_REG: s_next.rdata = {2'b00, s_reg.rclk, s_reg.transmit_timer_two_select, 4'h0};
                `ADR_BAUD_GENERATOR_CONTROL_REG: s_next.rdata = {3'b000, s_reg.brr, s_reg.transmit_generator_select, s_reg.receive_generator_select,
                                             s_reg.speed_bit, 1'b0};
                `ADR_BRL: s_next.rdata = s_reg.baud_reload_value;
                `ADR_SLAVE_ADDRESS: s_next.rdata = s_reg.slave_address;
                `ADR_SLAVE_ADDRESS_MASK: s_next.rdata = s_reg.slave_address_mask;
                default: s_next.rdata = 8'h00;
            endcase
        end

        // internal generator
        if (s_reg.brr) begin
            s_next.brg_pre = pre_tc ? 4'h0 : s_reg.brg_pre + 4'h1;
            if (pre_tc) begin
                s_next.brg_cnt = (s_reg.brg_cnt == `BRG_TOP) ? s_reg.baud_reload_value
                                 : s_reg.brg_cnt + 8'h01;
            end
            if (brg_ovf) begin
                s_next.brg_half = !s_reg.brg_half;
            end
        end else begin
            s_next.brg_pre = 4'h0;
            s_next.brg_cnt = s_reg.baud_reload_value;
        end

        // transmitter, independent of the receiver
        if (tx_tick && s_reg.tx_st != ST_IDLE) begin
            s_next.tx_ph = s_reg.tx_ph + 4'h1;
            if (s_reg.tx_ph == `OVS_LAST) begin
                case (s_reg.tx_st)
                    ST_START: begin
                        s_next.tx_st = ST_DATA;
                        s_next.txd = s_reg.tx_sh[0];
                        s_next.tx_sh = {1'b1, s_reg.tx_sh[8:1]};
                        s_next.tx_n = 4'h1;
                    end
                    ST_DATA: begin
                        if (s_reg.tx_n == nbits) begin
                            s_next.tx_st = ST_STOP;
                            s_next.txd = 1'b1;
                            s_next.ti = 1'b1;
                        end else begin
                            s_next.txd = s_reg.tx_sh[0];
                            s_next.tx_sh = {1'b1, s_reg.tx_sh[8:1]};
                            s_next.tx_n = s_reg.tx_n + 4'h1;
                        end
                    end
                    ST_STOP: s_next.tx_st = ST_IDLE;
                    default: s_next.tx_st = ST_IDLE;
                endcase
            end
        end

        // receiver
        case (s_reg.rx_st)
            ST_IDLE: begin
                if (s_reg.ren && mode != 2'b00 && s_reg.rx_prev && !RXD_I) begin
                    s_next.rx_st = ST_START;
                    s_next.rx_ph = 4'h0;
                    s_next.rx_n = 4'h0;
                    s_next.rx_acc = 1'b0;
                end
            end
            ST_START: begin
                if (rx_tick) begin
                    s_next.rx_ph = s_reg.rx_ph + 4'h1;
                    if (rx_mid && RXD_I) begin
                        s_next.rx_st = ST_IDLE;
                    end else if (s_reg.rx_ph == `OVS_LAST) begin
                        s_next.rx_st = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (rx_tick) begin
                    s_next.rx_ph = s_reg.rx_ph + 4'h1;
                    if (rx_mid) begin
                        s_next.rx_sh = rx_shifted;
                        s_next.rx_n = s_reg.rx_n + 4'h1;
                    end
                    if (s_reg.rx_ph == `OVS_LAST && s_reg.rx_n == nbits) begin
                        s_next.rx_st = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (rx_tick) begin
                    s_next.rx_ph = s_reg.rx_ph + 4'h1;
                    if (rx_mid) begin
                        // early decision in mode 1 still reports the stop level
                        if (s_reg.rx_acc && mode == 2'b01) begin
                            s_next.rb8 = RXD_I;
                        end
                        s_next.rx_st = ST_IDLE;
                    end
                end
            end
            default: s_next.rx_st = ST_IDLE;
        endcase

        // hardware sets come last so they win over a software clear
        if (ri_set) begin
            s_next.ri = 1'b1;
            s_next.rx_buf = dec_data;
            s_next.rb8 = dec_b9;
            s_next.rx_acc = 1'b1;
        end
        if (fe_set) begin
            s_next.fe = 1'b1;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s_reg <= '0;
            s_reg.slave_address <= `RST_BYTE;
            s_reg.slave_address_mask <= `RST_BYTE;
            s_reg.txd <= 1'b1;
            s_reg.rx_prev <= 1'b1;
            s_reg.tx_st <= ST_IDLE;
            s_reg.rx_st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA_O = s_reg.rdata;
    assign TXD_O = s_reg.txd;

    // ==========================================================
    // checks
    fe_sticky_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        s_reg.fe && !(wr_serial_control_reg && s_reg.framing_check_enable) |=> s_reg.fe)
        else $error("framing flag dropped without software clear");

    fe_on_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (s_reg.rx_st == ST_STOP) && rx_mid && s_reg.framing_check_enable && !RXD_I |=> s_reg.fe)
        else $error("bad stop bit did not set framing flag");

    ri_match_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ri_set && s_reg.sm2 |-> dec_b9 && addr_match(dec_data, s_reg.slave_address, s_reg.slave_address_mask))
        else $error("receive flag raised for foreign address");

    ri_late_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ri_set && s_reg.framing_check_enable |-> s_reg.rx_st == ST_STOP)
        else $error("receive flag raised before stop bit with check enabled");

    mode0_quiet_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        mode == 2'b00 && s_reg.rx_st == ST_IDLE |=> s_reg.rx_st == ST_IDLE)
        else $error("receiver started in mode 0");

    ti_at_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        s_reg.tx_st == ST_DATA ##1 s_reg.tx_st == ST_STOP |-> s_reg.ti && s_reg.txd)
        else $error("transmit flag missing at stop bit");

    brg_reload_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        brg_ovf |=> s_reg.brg_cnt == $past(s_reg.baud_reload_value))
        else $error("generator did not reload");

    tx_src_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        mode != 2'b10 && !s_reg.transmit_generator_select && s_reg.transmit_timer_two_select |-> tx_tick == TIMER_TICK_I.t2_ovf)
        else $error("transmit clock not from timer 2");

    rx_src_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        mode != 2'b10 && s_reg.receive_generator_select |-> rx_tick == brg_tick)
        else $error("receive clock not from generator");

    serial_control_reg_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        SFR_REQ_I.rd && SFR_REQ_I.addr == `ADR_SERIAL_CONTROL_REG && s_reg.framing_check_enable
        |=> RDATA_O[7] == $past(s_reg.fe))
        else $error("serial_control_reg bit 7 not showing framing flag");

endmodule

// ### test/remote_node.sv
`timescale 1ns/1ps
// ==========================================================
// remote serial node: drives the device receive line, listens to its transmit line
module remote_node (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    // the receive line idles high, driven by this node from the start
    initial rxd_o = 1'b1;

    // start bit, nb bits lsb first, stop level, then one idle bit
    task automatic send(input logic [8:0] d, input int nb, input logic stp, input int per);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (per) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            rxd_o <= d[i];
            repeat (per) @(posedge clk_i);
        end
        rxd_o <= stp;
        repeat (per) @(posedge clk_i);
        rxd_o <= 1'b1;
        repeat (per) @(posedge clk_i);
    endtask

    // bits are taken at mid-bit so a wrong baud source smears the data visibly
    task automatic recv(output logic [8:0] d, input int nb, input int per, output logic stp);
        int w;
        w = 0;
        d = '0;
        while (txd_i !== 1'b0 && w < 20000) begin
            @(posedge clk_i);
            w++;
        end
        repeat (per / 2) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            repeat (per) @(posedge clk_i);
            d[i] = txd_i;
        end
        repeat (per) @(posedge clk_i);
        stp = txd_i;
    endtask
endmodule

// ### test/uart_addr_match_framing_brg_tb.sv
`timescale 1ns/1ps
`include "uart_defs.svh"
module uart_addr_match_framing_brg_tb;
    import uart_pkg::*;
    logic sys_clk;
    logic rst_b;
    sfr_req_t sfr_req;
    timer_tick_t timer_tick;
    logic rxd;
    logic [7:0] rdata;
    logic txd;
    int n_fail;
    int n_tests;
    int tick_cnt;
    logic [7:0] rv;
    logic [8:0] got;
    logic stp;
    // tx source / rx source per pass: t2/t1, gen/t2, t1/gen, t1/t1
    logic [7:0] dx_t2c [4] = '{8'h10, 8'h20, 8'h00, 8'h00};
    logic [7:0] dx_bdr [4] = '{8'h00, 8'h1a, 8'h16, 8'h00};
    int dx_txp [4] = '{80, 64, 48, 48};
    int dx_rxp [4] = '{48, 80, 64, 48};
    // slave address f1, mask fa: given 1111_0x0x, broadcast 1111_1x11
    logic [7:0] am_cfg [10] = '{8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hf0,
        8'h70, 8'h70, 8'h70, 8'h50};
    logic [8:0] am_d [10] = '{9'h1f0, 9'h1f2, 9'h1ff, 9'h1fb, 9'h1f3, 9'h0f0,
        9'h0f0, 9'h0f0, 9'h0f2, 9'h0f2};
    logic am_stp [10] = '{1, 1, 1, 1, 1, 1, 1, 0, 1, 1};
    logic am_acc [10] = '{1, 0, 1, 1, 0, 0, 1, 0, 0, 1};

    uart_addr_match_framing_brg DUT (
        .SYS_CLK_I(sys_clk),
        .RST_B_I(rst_b),
        .SFR_REQ_I(sfr_req),
        .TIMER_TICK_I(timer_tick),
        .RXD_I(rxd),
        .RDATA_O(rdata),
        .TXD_O(txd)
    );

    remote_node node (
        .clk_i(sys_clk),
        .txd_i(txd),
        .rxd_o(rxd)
    );

    // ==========================================================
    // clock, timer ticks and bus access
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        rst_b = 1'b0;
        sfr_req = '0;
        timer_tick = '0;
        tick_cnt = 0;
        n_fail = 0;
        n_tests = 0;
    end

    // timer 1 gives 48 clocks a bit, timer 2 gives 80, so a wrong pick shows
    always @(posedge sys_clk) begin
        tick_cnt <= tick_cnt + 1;
        timer_tick.t1_ovf <= (tick_cnt % 3 == 0);
        timer_tick.t2_ovf <= (tick_cnt % 5 == 0);
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        sfr_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        sfr_req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // the whole sequence needs about 11000 clocks
    initial begin
        #1500000;
        n_fail++;
        conclude();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(`ADR_SLAVE_ADDRESS, rv);
        check({1'b0, rv}, 9'h000);
        rd(`ADR_SLAVE_ADDRESS_MASK, rv);
        check({1'b0, rv}, 9'h000);
        rd(`ADR_SERIAL_CONTROL_REG, rv);
        check({1'b0, rv}, 9'h000);
        rd(8'h10, rv);
        check({1'b0, rv}, 9'h000);
        // generator: fast prescale, doubling, reload fe gives 64 clocks a bit
        wr(`ADR_POWER_CONTROL_REG, 8'h80);
        wr(`ADR_BRL, 8'hfe);
        wr(`ADR_SERIAL_CONTROL_REG, 8'h50);
        for (int i = 0; i < 4; i++) begin
            wr(`ADR_TIMER_TWO_CONTROL_REG, dx_t2c[i]);
            wr(`ADR_BAUD_GENERATOR_CONTROL_REG, dx_bdr[i]);
            fork
                wr(`ADR_SBUF, 8'h96 + 8'(i));
                node.recv(got, 8, dx_txp[i], stp);
                node.send({1'b0, 8'h69 - 8'(i)}, 8, 1'b1, dx_rxp[i]);
            join
            check(got, {1'b0, 8'h96 + 8'(i)});
            rd(`ADR_SERIAL_CONTROL_REG, rv);
            check({1'b0, rv}, 9'h057);
            rd(`ADR_SBUF, rv);
            check({1'b0, rv}, {1'b0, 8'h69 - 8'(i)});
            wr(`ADR_SERIAL_CONTROL_REG, 8'h50);
            // in the first pass the stop bit is still on the line; a buffer write then would be dropped
            repeat (100) @(posedge sys_clk);
        end
        // mode 2 with doubling: 16 clocks a bit, ninth bit from tb8
        wr(`ADR_SERIAL_CONTROL_REG, 8'h98);
        fork
            wr(`ADR_SBUF, 8'h3c);
            node.recv(got, 9, 16, stp);
        join
        check(got, 9'h13c);
        check({8'h00, stp}, 9'h001);
        // ==========================================================
        // framing check: bad stop, then a good frame must not clear the flag
        wr(`ADR_TIMER_TWO_CONTROL_REG, 8'h00);
        wr(`ADR_BAUD_GENERATOR_CONTROL_REG, 8'h00);
        wr(`ADR_SERIAL_CONTROL_REG, 8'h50);
        wr(`ADR_POWER_CONTROL_REG, 8'hc0);
        node.send(9'h0a5, 8, 1'b0, 48);
        rd(`ADR_SERIAL_CONTROL_REG, rv);
        check({1'b0, rv}, 9'h0d1);
        wr(`ADR_SERIAL_CONTROL_REG, 8'hd0);
        fork
            node.send(9'h03c, 8, 1'b1, 48);
            begin
                // between mid of the last data bit and mid of the stop bit
                repeat (430) @(posedge sys_clk);
                rd(`ADR_SERIAL_CONTROL_REG, rv);
                check({1'b0, rv}, 9'h0d0);
            end
        join
        rd(`ADR_SERIAL_CONTROL_REG, rv);
        check({1'b0, rv}, 9'h0d5);
        wr(`ADR_SERIAL_CONTROL_REG, 8'h50);
        rd(`ADR_SERIAL_CONTROL_REG, rv);
        check({1'b0, rv}, 9'h050);
        wr(`ADR_POWER_CONTROL_REG, 8'h80);
        // ==========================================================
        // address recognition in modes 3 and 1
        wr(`ADR_SLAVE_ADDRESS, 8'hf1);
        wr(`ADR_SLAVE_ADDRESS_MASK, 8'hfa);
        rd(`ADR_SLAVE_ADDRESS_MASK, rv);
        check({1'b0, rv}, 9'h0fa);
        for (int i = 0; i < 10; i++) begin
            wr(`ADR_SERIAL_CONTROL_REG, am_cfg[i]);
            node.send(am_d[i], am_cfg[i][7] ? 9 : 8, am_stp[i], 48);
            rd(`ADR_SERIAL_CONTROL_REG, rv);
            check({1'b0, rv}, {1'b0, am_cfg[i] | (am_acc[i] ? 8'h05 : 8'h00)});
        end
        // second reset: cleared address bytes accept any address
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(`ADR_SLAVE_ADDRESS, rv);
        check({1'b0, rv}, 9'h000);
        wr(`ADR_SERIAL_CONTROL_REG, 8'hf0);
        node.send(9'h1a5, 9, 1'b1, 48);
        rd(`ADR_SERIAL_CONTROL_REG, rv);
        check({1'b0, rv}, 9'h0f5);
        rd(`ADR_SBUF, rv);
        check({1'b0, rv}, 9'h0a5);
        conclude();
    end
endmodule
